// ==== charge_state_pkg.sv ====
// constants, register map and field layout for the charge-state flag block
// assumes a plain address/strobe register port with 32-bit data words
package charge_state_pkg;
  // register indices and byte addresses
  localparam logic [7:0] ADDR_FLAG_CFG = 8'h00;
  localparam logic [7:0] ADDR_GAUGE_CFG = 8'h04;
  localparam logic [7:0] ADDR_FULL_CLR_PCT = 8'h08;
  localparam logic [7:0] ADDR_FULL_SET_PCT = 8'h0c;
  localparam logic [7:0] ADDR_FULL_CLR_MV = 8'h10;
  localparam logic [7:0] ADDR_FULL_SET_MV = 8'h14;
  localparam logic [7:0] ADDR_EMPTY_CLR_PCT = 8'h18;
  localparam logic [7:0] ADDR_EMPTY_SET_PCT = 8'h1c;
  localparam logic [7:0] ADDR_EMPTY_CLR_MV = 8'h20;
  localparam logic [7:0] ADDR_EMPTY_SET_MV = 8'h24;
  localparam logic [7:0] ADDR_INH_LOW = 8'h28;
  localparam logic [7:0] ADDR_INH_HIGH = 8'h2c;
  localparam logic [7:0] ADDR_INH_HYS = 8'h30;
  localparam logic [7:0] ADDR_CC_PCT = 8'h34;
  localparam logic [7:0] ADDR_CC_FLOOR = 8'h38;
  localparam logic [7:0] ADDR_DOD_EDV = 8'h3c;
  localparam logic [7:0] ADDR_STATUS = 8'h40;
  localparam logic [7:0] ADDR_CYCLE_CNT = 8'h44;

  // flag configuration bit positions
  localparam int FULL_CLR_SOC = 7;
  localparam int FULL_SET_SOC = 6;
  localparam int FULL_CLR_V = 5;
  localparam int FULL_SET_V = 4;
  localparam int EMPTY_CLR_SOC = 3;
  localparam int EMPTY_SET_SOC = 2;
  localparam int EMPTY_CLR_V = 1;
  localparam int EMPTY_SET_V = 0;

  // gauging configuration bit positions (high byte = bits 15:8)
  localparam int GC_SMOOTH_DIS = 12;
  localparam int GC_LEARN_FULL = 10;
  localparam int GC_CAP_LIMIT = 8;
  localparam int GC_FIXED_LOW = 5;
  localparam int GC_CHARGER = 4;
  localparam int GC_COMP = 3;
  localparam int GC_SYNC = 1;
  localparam int GC_CYCLE_BASIS = 0;
  localparam logic [15:0] GC_WRITABLE = 16'h153b;

  // reset values
  localparam logic [7:0] FLAG_CFG_RST = 8'h8c;
  localparam logic [15:0] GAUGE_CFG_RST = 16'h0000;
  localparam logic [7:0] FULL_CLR_PCT_RST = 8'h5a;
  localparam logic [7:0] FULL_SET_PCT_RST = 8'h64;
  localparam logic [15:0] FULL_CLR_MV_RST = 16'h1004;
  localparam logic [15:0] FULL_SET_MV_RST = 16'h1068;
  localparam logic [7:0] EMPTY_CLR_PCT_RST = 8'h0a;
  localparam logic [7:0] EMPTY_SET_PCT_RST = 8'h00;
  localparam logic [15:0] EMPTY_CLR_MV_RST = 16'h0e10;
  localparam logic [15:0] EMPTY_SET_MV_RST = 16'h0bb8;
  // temperature limits in 0.1 degC, signed; hysteresis in 0.1 degC, unsigned
  localparam logic signed [15:0] INH_LOW_RST = 16'sh0000;
  localparam logic signed [15:0] INH_HIGH_RST = 16'sh01c2;
  localparam logic [15:0] INH_HYS_RST = 16'h0032;
  localparam logic [7:0] CC_PCT_RST = 8'h5a;
  localparam logic [15:0] CC_FLOOR_RST = 16'h0064;
  // 16384 means full depth
  localparam logic [15:0] DOD_FULL = 16'h4000;
  localparam logic [15:0] DOD_EDV_RST = 16'h3b80;
  localparam logic [7:0] PCT_FULL = 8'h64;
endpackage

// ==== charge_state_flags.sv ====
// charge-state flag logic: full/empty flags, gauging option decode,
// charge inhibit with hysteresis, cycle counting and capacity clamps.
// assumes gauge measurements arrive synchronous to clk, with an eval
// strobe per gauging pass; registers reached over a plain strobe port.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module charge_state_flags
  import charge_state_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic eval,
  input wire logic [7:0] relative_charge_pct,
  input wire logic [15:0] voltage_mv,
  input wire logic signed [15:0] temperature,
  input wire logic [15:0] design_capacity,
  input wire logic [15:0] full_capacity,
  input wire logic [15:0] learned_capacity,
  input wire logic [15:0] remaining_raw,
  input wire logic [15:0] reserve_capacity,
  input wire logic [15:0] dynamic_low_threshold,
  input wire logic [15:0] fixed_low_threshold,
  input wire logic [15:0] comp_high_threshold,
  input wire logic [15:0] fixed_high_threshold,
  input wire logic [15:0] dod_now,
  input wire logic [15:0] discharge_mah,
  input wire logic discharge_qualified_raw,
  input wire logic charge_terminated,
  output logic full_charge_flag,
  output logic full_discharge_flag,
  output logic charge_inhibit_flag,
  output logic charge_allowed,
  output logic smoothing_enable,
  output logic learn_for_smart_charger,
  output logic learning_discharge_qualified,
  output logic [15:0] full_capacity_out,
  output logic [15:0] remaining_capacity,
  output logic [15:0] lowest_discharge_threshold,
  output logic [15:0] highest_discharge_threshold,
  output logic [15:0] dod_at_high_threshold,
  output logic [15:0] cycle_count
);

  logic [7:0] flag_cfg_q;
  logic [15:0] gauge_cfg_q;
  logic [7:0] full_clr_pct_q, full_set_pct_q, empty_clr_pct_q, empty_set_pct_q;
  logic [15:0] full_clr_mv_q, full_set_mv_q, empty_clr_mv_q, empty_set_mv_q;
  logic signed [15:0] inh_low_q, inh_high_q;
  logic [15:0] inh_hys_q;
  logic [7:0] cc_pct_q;
  logic [15:0] cc_floor_q;
  logic [15:0] cycle_acc_q;
  logic [15:0] cycle_acc_d;
  logic [15:0] cycle_step;
  logic [23:0] share_prod;
  logic [15:0] cycle_basis;
  logic full_set, full_clr, empty_set, empty_clr;
  logic at_high_threshold;
  logic signed [16:0] low_release, high_release;

  // register writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_cfg_q <= FLAG_CFG_RST;
      gauge_cfg_q <= GAUGE_CFG_RST;
      full_clr_pct_q <= FULL_CLR_PCT_RST;
      full_set_pct_q <= FULL_SET_PCT_RST;
      full_clr_mv_q <= FULL_CLR_MV_RST;
      full_set_mv_q <= FULL_SET_MV_RST;
      empty_clr_pct_q <= EMPTY_CLR_PCT_RST;
      empty_set_pct_q <= EMPTY_SET_PCT_RST;
      empty_clr_mv_q <= EMPTY_CLR_MV_RST;
      empty_set_mv_q <= EMPTY_SET_MV_RST;
      inh_low_q <= INH_LOW_RST;
      inh_high_q <= INH_HIGH_RST;
      inh_hys_q <= INH_HYS_RST;
      cc_pct_q <= CC_PCT_RST;
      cc_floor_q <= CC_FLOOR_RST;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_FLAG_CFG) begin
        flag_cfg_q <= reg_wdata[7:0];
      end else if (reg_addr == ADDR_GAUGE_CFG) begin
        // reserved bits stay zero
        gauge_cfg_q <= reg_wdata[15:0] & GC_WRITABLE;
      end else if (reg_addr == ADDR_FULL_CLR_PCT) begin
        full_clr_pct_q <= reg_wdata[7:0];
      end else if (reg_addr == ADDR_FULL_SET_PCT) begin
        full_set_pct_q <= reg_wdata[7:0];
      end else if (reg_addr == ADDR_FULL_CLR_MV) begin
        full_clr_mv_q <= reg_wdata[15:0];
      end else if (reg_addr == ADDR_FULL_SET_MV) begin
        full_set_mv_q <= reg_wdata[15:0];
      end else if (reg_addr == ADDR_EMPTY_CLR_PCT) begin
        empty_clr_pct_q <= reg_wdata[7:0];
      end else if (reg_addr == ADDR_EMPTY_SET_PCT) begin
        empty_set_pct_q <= reg_wdata[7:0];
      end else if (reg_addr == ADDR_EMPTY_CLR_MV) begin
        empty_clr_mv_q <= reg_wdata[15:0];
      end else if (reg_addr == ADDR_EMPTY_SET_MV) begin
        empty_set_mv_q <= reg_wdata[15:0];
      end else if (reg_addr == ADDR_INH_LOW) begin
        inh_low_q <= reg_wdata[15:0];
      end else if (reg_addr == ADDR_INH_HIGH) begin
        inh_high_q <= reg_wdata[15:0];
      end else if (reg_addr == ADDR_INH_HYS) begin
        inh_hys_q <= reg_wdata[15:0];
      end else if (reg_addr == ADDR_CC_PCT) begin
        cc_pct_q <= reg_wdata[7:0];
      end else if (reg_addr == ADDR_CC_FLOOR) begin
        cc_floor_q <= reg_wdata[15:0];
      end
    end
  end

  // flag condition decode
  always_comb begin
    full_set = (flag_cfg_q[FULL_SET_SOC] && relative_charge_pct >= full_set_pct_q)
            || (flag_cfg_q[FULL_SET_V] && voltage_mv >= full_set_mv_q);
    full_clr = (flag_cfg_q[FULL_CLR_SOC] && relative_charge_pct <= full_clr_pct_q)
            || (flag_cfg_q[FULL_CLR_V] && voltage_mv <= full_clr_mv_q);
    empty_set = (flag_cfg_q[EMPTY_SET_SOC] && relative_charge_pct <= empty_set_pct_q)
             || (flag_cfg_q[EMPTY_SET_V] && voltage_mv <= empty_set_mv_q);
    empty_clr = (flag_cfg_q[EMPTY_CLR_SOC] && relative_charge_pct >= empty_clr_pct_q)
             || (flag_cfg_q[EMPTY_CLR_V] && voltage_mv >= empty_clr_mv_q);
  end

  // set wins if both apply on one pass, so a crossing is never lost
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      full_charge_flag <= 1'b0;
      full_discharge_flag <= 1'b0;
    end else if (eval) begin
      if (full_set) begin
        full_charge_flag <= 1'b1;
      end else if (full_clr) begin
        full_charge_flag <= 1'b0;
      end
      if (empty_set) begin
        full_discharge_flag <= 1'b1;
      end else if (empty_clr) begin
        full_discharge_flag <= 1'b0;
      end
    end
  end

  // temperature inhibit with hysteresis
  always_comb begin
    low_release = 17'(inh_low_q) + 17'(signed'({1'b0, inh_hys_q}));
    high_release = 17'(inh_high_q) - 17'(signed'({1'b0, inh_hys_q}));
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      charge_inhibit_flag <= 1'b0;
      charge_allowed <= 1'b1;
    end else if (eval) begin
      if (temperature < inh_low_q || temperature > inh_high_q) begin
        charge_inhibit_flag <= 1'b1;
        charge_allowed <= 1'b0;
      end else if (17'(temperature) > low_release && 17'(temperature) < high_release) begin
        charge_inhibit_flag <= 1'b0;
        charge_allowed <= 1'b1;
      end
    end
  end

  // gauging option decode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      smoothing_enable <= 1'b1;
      learn_for_smart_charger <= 1'b1;
      learning_discharge_qualified <= 1'b0;
      lowest_discharge_threshold <= 16'h0000;
      highest_discharge_threshold <= 16'h0000;
      full_capacity_out <= 16'h0000;
    end else begin
      smoothing_enable <= ~gauge_cfg_q[GC_SMOOTH_DIS];
      learn_for_smart_charger <= ~gauge_cfg_q[GC_CHARGER];
      learning_discharge_qualified <= discharge_qualified_raw
        && (!gauge_cfg_q[GC_LEARN_FULL] || full_charge_flag);
      if (gauge_cfg_q[GC_COMP] && !gauge_cfg_q[GC_FIXED_LOW]) begin
        lowest_discharge_threshold <= dynamic_low_threshold;
      end else begin
        lowest_discharge_threshold <= fixed_low_threshold;
      end
      highest_discharge_threshold <= gauge_cfg_q[GC_COMP] ?
        comp_high_threshold : fixed_high_threshold;
      if (gauge_cfg_q[GC_CAP_LIMIT] && learned_capacity > design_capacity) begin
        full_capacity_out <= design_capacity;
      end else begin
        full_capacity_out <= learned_capacity;
      end
    end
  end

  // remaining capacity: sync on termination, zero inside reserve
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      remaining_capacity <= 16'h0000;
    end else if (gauge_cfg_q[GC_SYNC] && charge_terminated) begin
      remaining_capacity <= full_capacity;
    end else if (remaining_raw <= reserve_capacity) begin
      remaining_capacity <= 16'h0000;
    end else begin
      remaining_capacity <= remaining_raw - reserve_capacity;
    end
  end

  // depth-of-discharge capture on every eval pass at or below the highest threshold
  assign at_high_threshold = voltage_mv <= highest_discharge_threshold;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dod_at_high_threshold <= DOD_EDV_RST;
    end else if (eval && at_high_threshold) begin
      dod_at_high_threshold <= (dod_now > DOD_FULL) ? DOD_FULL : dod_now;
    end
  end

  // cycle counting; floor keeps a tiny basis from counting too fast
  always_comb begin
    cycle_basis = gauge_cfg_q[GC_CYCLE_BASIS] ? full_capacity : design_capacity;
    // widen before the product, or a large basis wraps past 16 bits
    share_prod = (24'(cycle_basis) * 24'(cc_pct_q)) / 24'(PCT_FULL);
    if (share_prod[23:16] != 8'h00) begin
      cycle_step = 16'hffff;
    end else if (share_prod[15:0] < cc_floor_q) begin
      cycle_step = cc_floor_q;
    end else begin
      cycle_step = share_prod[15:0];
    end
    cycle_acc_d = cycle_acc_q + discharge_mah;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cycle_acc_q <= 16'h0000;
      cycle_count <= 16'h0000;
    end else if (eval) begin
      if (cycle_step != 16'h0000 && cycle_acc_d >= cycle_step) begin
        cycle_acc_q <= cycle_acc_d - cycle_step;
        cycle_count <= cycle_count + 16'h0001;
      end else begin
        cycle_acc_q <= cycle_acc_d;
      end
    end
  end

  // register reads, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_FLAG_CFG) begin
        reg_rdata <= {24'h000000, flag_cfg_q};
      end else if (reg_addr == ADDR_GAUGE_CFG) begin
        reg_rdata <= {16'h0000, gauge_cfg_q};
      end else if (reg_addr == ADDR_FULL_CLR_PCT) begin
        reg_rdata <= {24'h000000, full_clr_pct_q};
      end else if (reg_addr == ADDR_FULL_SET_PCT) begin
        reg_rdata <= {24'h000000, full_set_pct_q};
      end else if (reg_addr == ADDR_FULL_CLR_MV) begin
        reg_rdata <= {16'h0000, full_clr_mv_q};
      end else if (reg_addr == ADDR_FULL_SET_MV) begin
        reg_rdata <= {16'h0000, full_set_mv_q};
      end else if (reg_addr == ADDR_EMPTY_CLR_PCT) begin
        reg_rdata <= {24'h000000, empty_clr_pct_q};
      end else if (reg_addr == ADDR_EMPTY_SET_PCT) begin
        reg_rdata <= {24'h000000, empty_set_pct_q};
      end else if (reg_addr == ADDR_EMPTY_CLR_MV) begin
        reg_rdata <= {16'h0000, empty_clr_mv_q};
      end else if (reg_addr == ADDR_EMPTY_SET_MV) begin
        reg_rdata <= {16'h0000, empty_set_mv_q};
      end else if (reg_addr == ADDR_INH_LOW) begin
        reg_rdata <= {16'h0000, inh_low_q};
      end else if (reg_addr == ADDR_INH_HIGH) begin
        reg_rdata <= {16'h0000, inh_high_q};
      end else if (reg_addr == ADDR_INH_HYS) begin
        reg_rdata <= {16'h0000, inh_hys_q};
      end else if (reg_addr == ADDR_CC_PCT) begin
        reg_rdata <= {24'h000000, cc_pct_q};
      end else if (reg_addr == ADDR_CC_FLOOR) begin
        reg_rdata <= {16'h0000, cc_floor_q};
      end else if (reg_addr == ADDR_DOD_EDV) begin
        reg_rdata <= {16'h0000, dod_at_high_threshold};
      end else if (reg_addr == ADDR_STATUS) begin
        reg_rdata <= {28'h0000000, learning_discharge_qualified, charge_inhibit_flag,
          full_discharge_flag, full_charge_flag};
      end else if (reg_addr == ADDR_CYCLE_CNT) begin
        reg_rdata <= {16'h0000, cycle_count};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

endmodule

// ==== charge_state_checker.sv ====
// assertions on the ports of charge_state_flags
// assumes one clock domain; decoded outputs lag their causes by one clock
`timescale 1ns/10ps
module charge_state_checker
  import charge_state_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic eval,
  input wire logic [15:0] design_capacity,
  input wire logic [15:0] full_capacity,
  input wire logic [15:0] learned_capacity,
  input wire logic [15:0] remaining_raw,
  input wire logic [15:0] reserve_capacity,
  input wire logic [15:0] dynamic_low_threshold,
  input wire logic [15:0] fixed_low_threshold,
  input wire logic [15:0] comp_high_threshold,
  input wire logic [15:0] fixed_high_threshold,
  input wire logic discharge_qualified_raw,
  input wire logic charge_terminated,
  input wire logic full_charge_flag,
  input wire logic full_discharge_flag,
  input wire logic charge_inhibit_flag,
  input wire logic charge_allowed,
  input wire logic smoothing_enable,
  input wire logic learn_for_smart_charger,
  input wire logic learning_discharge_qualified,
  input wire logic [15:0] full_capacity_out,
  input wire logic [15:0] remaining_capacity,
  input wire logic [15:0] lowest_discharge_threshold,
  input wire logic [15:0] highest_discharge_threshold,
  input wire logic [15:0] dod_at_high_threshold,
  input wire logic [15:0] cycle_count
);
  // shadow of the gauging options word, snooped from register writes
  logic [15:0] gcfg_q;
  logic [15:0] low_e, high_e, cap_e, rem_e;
  logic lq_e;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gcfg_q <= GAUGE_CFG_RST;
    end else if (reg_wr && reg_addr == ADDR_GAUGE_CFG) begin
      gcfg_q <= reg_wdata[15:0] & GC_WRITABLE;
    end
  end
  always_comb begin
    low_e = (gcfg_q[GC_COMP] && !gcfg_q[GC_FIXED_LOW]) ? dynamic_low_threshold : fixed_low_threshold;
    high_e = gcfg_q[GC_COMP] ? comp_high_threshold : fixed_high_threshold;
    cap_e = (gcfg_q[GC_CAP_LIMIT] && learned_capacity > design_capacity) ? design_capacity
      : learned_capacity;
    rem_e = (gcfg_q[GC_SYNC] && charge_terminated) ? full_capacity
      : (remaining_raw <= reserve_capacity) ? 16'h0000 : remaining_raw - reserve_capacity;
    lq_e = discharge_qualified_raw && (!gcfg_q[GC_LEARN_FULL] || full_charge_flag);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  flags_hold_a: assert property (
    !eval |=> $stable({full_charge_flag, full_discharge_flag, charge_inhibit_flag}))
    else $error("status flag moved without eval");
  inhibit_move_a: assert property (
    $changed(charge_inhibit_flag) |-> $past(eval) && charge_allowed == !charge_inhibit_flag)
    else $error("inhibit changed badly");
  smooth_decode_a: assert property (
    1 |=> smoothing_enable == !$past(gcfg_q[GC_SMOOTH_DIS])) else $error("smoothing decode");
  charger_decode_a: assert property (
    1 |=> learn_for_smart_charger == !$past(gcfg_q[GC_CHARGER])) else $error("charger decode");
  learn_gate_a: assert property (
    !eval |=> learning_discharge_qualified == $past(lq_e)) else $error("learning gate");
  cap_limit_a: assert property (
    1 |=> full_capacity_out == $past(cap_e)) else $error("capacity clamp");
  low_thr_a: assert property (
    1 |=> lowest_discharge_threshold == $past(low_e)) else $error("lowest threshold");
  high_thr_a: assert property (
    1 |=> highest_discharge_threshold == $past(high_e)) else $error("highest threshold");
  remaining_a: assert property (
    1 |=> remaining_capacity == $past(rem_e)) else $error("remaining capacity");
  cycle_step_a: assert property (
    eval |=> cycle_count == $past(cycle_count) || cycle_count == $past(cycle_count) + 16'h1)
    else $error("cycle count jumped");
  dod_hold_a: assert property (
    !eval |=> $stable(cycle_count) && $stable(dod_at_high_threshold))
    else $error("count or depth moved without eval");
  cover property ($rose(full_charge_flag));
  cover property ($rose(charge_inhibit_flag));
  cover property ($changed(cycle_count));
endmodule
bind charge_state_flags charge_state_checker chk (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
  .eval, .design_capacity, .full_capacity, .learned_capacity, .remaining_raw,
  .reserve_capacity, .dynamic_low_threshold, .fixed_low_threshold, .comp_high_threshold,
  .fixed_high_threshold, .discharge_qualified_raw, .charge_terminated, .full_charge_flag,
  .full_discharge_flag, .charge_inhibit_flag, .charge_allowed, .smoothing_enable,
  .learn_for_smart_charger, .learning_discharge_qualified, .full_capacity_out,
  .remaining_capacity, .lowest_discharge_threshold, .highest_discharge_threshold,
  .dod_at_high_threshold, .cycle_count);

// ==== tb.sv ====
// self-checking bench for charge_state_flags
// assumes the package and the bound checker are compiled first
`timescale 1ns/10ps
module tb;
  import charge_state_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, eval = 1'b0;
  logic discharge_qualified_raw = 1'b1, charge_terminated = 1'b1;
  logic [7:0] reg_addr = 8'h00, relative_charge_pct = 8'd50;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [15:0] voltage_mv = 16'h0d00, design_capacity = 16'd1000, full_capacity = 16'd100;
  logic [15:0] learned_capacity = 16'd1200, remaining_raw = 16'd500, reserve_capacity = 16'd100;
  logic [15:0] dynamic_low_threshold = 16'h0bb9, fixed_low_threshold = 16'h0bba;
  logic [15:0] comp_high_threshold = 16'h0dad, fixed_high_threshold = 16'h0dac;
  logic [15:0] dod_now = 16'h2000, discharge_mah = 16'h0;
  logic signed [15:0] temperature = 16'sd250;
  logic full_charge_flag, full_discharge_flag, charge_inhibit_flag, charge_allowed;
  logic smoothing_enable, learn_for_smart_charger, learning_discharge_qualified;
  logic [15:0] full_capacity_out, remaining_capacity, lowest_discharge_threshold;
  logic [15:0] highest_discharge_threshold, dod_at_high_threshold, cycle_count;
  int n_errors = 0, num_checks = 0, cycles = 0;
  charge_state_flags dut (.*);
  always #4 clk = ~clk;
  task automatic test_done();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // stuck handshakes cannot happen here, so a plain ceiling suffices
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // callers change the measurements at an edge just before this
  task automatic ev();
    @(posedge clk);
    eval <= 1'b1;
    @(posedge clk);
    eval <= 1'b0;
    #1;
  endtask
  task automatic regs_test();
    logic [31:0] rv[19] = '{FLAG_CFG_RST, GAUGE_CFG_RST, FULL_CLR_PCT_RST, FULL_SET_PCT_RST,
      FULL_CLR_MV_RST, FULL_SET_MV_RST, EMPTY_CLR_PCT_RST, EMPTY_SET_PCT_RST, EMPTY_CLR_MV_RST,
      EMPTY_SET_MV_RST, INH_LOW_RST, INH_HIGH_RST, INH_HYS_RST, CC_PCT_RST, CC_FLOOR_RST,
      DOD_EDV_RST, 32'h8, 32'h0, 32'h0};
    for (int i = 0; i < 19; i++) begin
      rd(8'(i * 4), d);
      chk("register reset value", rv[i], d);
    end
    wr(ADDR_STATUS, 32'hf);
    wr(ADDR_DOD_EDV, 32'h0);
    rd(ADDR_DOD_EDV, d);
    chk("depth after ignored write", 32'h3b80, d);
    wr(ADDR_GAUGE_CFG, 32'hffff);
    rd(ADDR_GAUGE_CFG, d);
    chk("gauge cfg writable mask", 32'h153b, d);
  endtask
  task automatic flag_test();
    // cfg, charge %, voltage, expected full and empty flags
    logic [33:0] ft[13] = '{{8'h00, 8'd100, 16'h0d00, 2'b00}, {8'h40, 8'd99, 16'h0d00, 2'b00},
      {8'h40, 8'd100, 16'h0d00, 2'b10}, {8'h80, 8'd91, 16'h0d00, 2'b10},
      {8'h80, 8'd90, 16'h0d00, 2'b00}, {8'h10, 8'd50, 16'h1068, 2'b10},
      {8'h20, 8'd50, 16'h1004, 2'b00}, {8'h04, 8'd0, 16'h0d00, 2'b01},
      {8'h08, 8'd10, 16'h0d00, 2'b00}, {8'h01, 8'd50, 16'h0bb8, 2'b01},
      {8'h02, 8'd50, 16'h0e10, 2'b00}, {8'h60, 8'd100, 16'h0d00, 2'b10},
      {8'h80, 8'd50, 16'h0d00, 2'b00}};
    wr(ADDR_GAUGE_CFG, 32'h0);
    for (int i = 0; i < 13; i++) begin
      wr(ADDR_FLAG_CFG, {24'h0, ft[i][33:26]});
      relative_charge_pct <= ft[i][25:18];
      voltage_mv <= ft[i][17:2];
      ev();
      chk("full and empty flags", ft[i][1:0], {full_charge_flag, full_discharge_flag});
    end
    rd(ADDR_STATUS, d);
    chk("status word", 32'h8, d);
  endtask
  task automatic decode_test();
    logic [15:0] cv[4] = '{16'h0000, 16'h0008, 16'h0028, 16'h153b};
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_GAUGE_CFG, {16'h0, cv[i]});
      repeat (2) @(posedge clk);
      #1;
      chk("smoothing", !cv[i][12], smoothing_enable);
      chk("charger type", !cv[i][4], learn_for_smart_charger);
      chk("learn gate", !cv[i][10], learning_discharge_qualified);
      chk("capacity", cv[i][8] ? 16'd1000 : 16'd1200, full_capacity_out);
      chk("remaining", cv[i][1] ? 16'd100 : 16'd400, remaining_capacity);
      chk("lowest", cv[i] == 16'h0008 ? 16'h0bb9 : 16'h0bba, lowest_discharge_threshold);
      chk("highest", cv[i][3] ? 16'h0dad : 16'h0dac, highest_discharge_threshold);
    end
    @(posedge clk);
    remaining_raw <= 16'd100;
    charge_terminated <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("remaining in reserve", 16'h0, remaining_capacity);
  endtask
  task automatic inhibit_test();
    logic signed [15:0] tt[7] = '{-16'sd1, 16'sd50, 16'sd51, 16'sd451, 16'sd400, 16'sd399, 16'sd450};
    logic [6:0] ie = 7'b1101100;
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      temperature <= tt[i];
      ev();
      chk("inhibit", ie[6 - i], charge_inhibit_flag);
      chk("charge allowed", !ie[6 - i], charge_allowed);
    end
  endtask
  task automatic evd(input logic [15:0] dm);
    @(posedge clk);
    discharge_mah <= dm;
    ev();
  endtask
  task automatic cycle_test();
    wr(ADDR_GAUGE_CFG, 32'h0);
    evd(16'd450);
    evd(16'd449);
    chk("cycles below step", 16'd0, cycle_count);
    evd(16'd1);
    chk("cycles at design step", 16'd1, cycle_count);
    wr(ADDR_GAUGE_CFG, 32'h1);
    evd(16'd99);
    chk("cycles below floor", 16'd1, cycle_count);
    evd(16'd1);
    chk("cycles at floor", 16'd2, cycle_count);
    wr(ADDR_GAUGE_CFG, 32'h0);
    // earlier passes below the threshold already captured 0x2000
    @(posedge clk);
    voltage_mv <= 16'h0dad;
    dod_now <= 16'h3000;
    evd(16'd0);
    chk("depth above threshold", 16'h2000, dod_at_high_threshold);
    @(posedge clk);
    voltage_mv <= 16'h0dac;
    evd(16'd0);
    chk("depth at threshold", 16'h3000, dod_at_high_threshold);
    @(posedge clk);
    dod_now <= 16'h5000;
    evd(16'd0);
    chk("depth clamped to full", 16'h4000, dod_at_high_threshold);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    regs_test();
    flag_test();
    decode_test();
    inhibit_test();
    cycle_test();
    test_done();
  end
endmodule
